// >>> verilog/tcf_timer_regs.sv
// Control, flag and 16-bit data registers of a four-channel timer/counter.
// Assumes the core supplies prescaled ticks, mode and event strobes.
`timescale 1ns/1ns
module tcf_timer_regs import tcf_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire tcf_bus_type bus,
	input wire tcf_wave_type wave_mode,
	input wire tcf_core_type core,
	input wire tcf_ack_type ack,
	output logic [7:0] rdata,
	output logic [15:0] count_value,
	output logic count_dir,
	output logic update_strobe,
	output logic [3:0] channel_match,
	output logic [1:0] irq_fault_level,
	output logic [1:0] irq_wrap_level,
	output logic [7:0] irq_channel_level,
	output logic [3:0] dma_req_channel,
	output logic dma_req_wrap
);
	logic [3:0] lvl_a_q;
	logic [7:0] lvl_b_q;
	logic hold_q;
	logic dir_q;
	logic [15:0] count_q;
	logic [15:0] count_next;
	logic count_moved_q;
	logic [15:0] top_q;
	logic [15:0] topbuf_q;
	logic top_bv_q;
	logic fault_flag_q;
	logic wrap_flag_q;
	logic [7:0] rdata_q;
	logic update_q;
	logic f_set_wr;
	logic f_clr_wr;
	logic g_set_wr;
	logic g_clr_wr;
	logic flags_wr;
	tcf_cmd_type cmd;
	logic cmd_update;
	logic cmd_restart;
	logic hard_rst;
	logic wide_sel;
	logic wide_wr;
	logic [15:0] wide_data;
	logic [15:0] wide_value;
	logic [7:0] latch_byte;
	logic [4:0] widx;
	logic hit_cnt;
	logic hit_top;
	logic hit_topbuf;
	logic dual;
	logic [15:0] cnt_top;
	logic at_top;
	logic at_bottom;
	logic tick;
	logic top_hit;
	logic bottom_hit;
	logic hw_update;
	logic update_go;
	logic wrap_event;
	logic wrap_clr;
	logic fault_set;
	logic [15:0] cc_val [TCF_CHANNELS];
	logic [15:0] buf_val [TCF_CHANNELS];
	logic [3:0] bv;
	logic [3:0] chan_flag;
	logic [3:0] overrun;
	logic [3:0] cc_hit;
	logic [3:0] buf_hit;
	logic [7:0] rd_d;

	assign f_set_wr = bus.wr && bus.addr == TCF_OFF_F_SET;
	assign f_clr_wr = bus.wr && bus.addr == TCF_OFF_F_CLR;
	assign g_set_wr = bus.wr && bus.addr == TCF_OFF_G_SET;
	assign g_clr_wr = bus.wr && bus.addr == TCF_OFF_G_CLR;
	assign flags_wr = bus.wr && bus.addr == TCF_OFF_FLAGS;
	assign cmd = tcf_cmd_type'(bus.wdata[TCF_CMD_LSB +: 2]);
	assign cmd_update = f_set_wr && cmd == TCF_CMD_UPDATE;
	assign cmd_restart = f_set_wr && cmd == TCF_CMD_RESTART;
	assign hard_rst = f_set_wr && cmd == TCF_CMD_RESET && core.clock_off;

	assign wide_sel = bus.addr >= TCF_OFF_CNT;
	assign widx = bus.addr[5:1];
	assign hit_cnt = wide_sel && widx == TCF_OFF_CNT[5:1];
	assign hit_top = wide_sel && widx == TCF_OFF_TOP[5:1];
	assign hit_topbuf = wide_sel && widx == TCF_OFF_TOPBUF[5:1];

	tcf_wide_access u_wide (
		.clk(clk),
		.rst_n(rst_n),
		.bus(bus),
		.wide_sel(wide_sel),
		.wide_value(wide_value),
		.wide_wr(wide_wr),
		.wide_data(wide_data),
		.latch_byte(latch_byte)
	);

	always_ff @(posedge clk) begin
		if (!rst_n || hard_rst) begin
			lvl_a_q <= 4'h0;
			lvl_b_q <= TCF_BYTE_RST;
		end else begin
			if (bus.wr && bus.addr == TCF_OFF_LVL_A) begin
				lvl_a_q <= bus.wdata[3:0];
			end
			if (bus.wr && bus.addr == TCF_OFF_LVL_B) begin
				lvl_b_q <= bus.wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || hard_rst) begin
			hold_q <= 1'b0;
		end else if (f_set_wr && bus.wdata[TCF_HOLD_BIT]) begin
			hold_q <= 1'b1;
		end else if (f_clr_wr && bus.wdata[TCF_HOLD_BIT]) begin
			hold_q <= 1'b0;
		end
	end

	// frequency mode takes its top from channel zero
	assign dual = wave_mode == TCF_WAVE_DS_T || wave_mode == TCF_WAVE_DS_TB
		|| wave_mode == TCF_WAVE_DS_B;
	assign cnt_top = wave_mode == TCF_WAVE_FRQ ? cc_val[0] : top_q;
	assign at_top = count_q == cnt_top;
	assign at_bottom = count_q == TCF_WIDE_RST;
	assign tick = core.count_tick;
	assign top_hit = tick && !dir_q && at_top;
	assign bottom_hit = tick && (dir_q ? at_bottom : at_top && !dual);

	always_comb begin
		if (!dir_q) begin
			if (at_top) begin
				count_next = dual ? count_q - 16'h0001 : TCF_WIDE_RST;
			end else begin
				count_next = count_q + 16'h0001;
			end
		end else begin
			if (at_bottom) begin
				count_next = dual ? count_q + 16'h0001 : cnt_top;
			end else begin
				count_next = count_q - 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_q <= TCF_WIDE_RST;
		end else if (wide_wr && hit_cnt) begin
			count_q <= wide_data;
		end else if (hard_rst || cmd_restart || core.hw_restart) begin
			count_q <= TCF_WIDE_RST;
		end else if (tick) begin
			count_q <= count_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_moved_q <= 1'b0;
		end else begin
			count_moved_q <= tick || (wide_wr && hit_cnt);
		end
	end

	// software write beats hardware steering
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dir_q <= 1'b0;
		end else if (f_set_wr && bus.wdata[TCF_DIR_BIT]) begin
			dir_q <= 1'b1;
		end else if (f_clr_wr && bus.wdata[TCF_DIR_BIT]) begin
			dir_q <= 1'b0;
		end else if (hard_rst || cmd_restart || core.hw_restart) begin
			dir_q <= 1'b0;
		end else if (core.dir_load) begin
			dir_q <= core.dir_value;
		end else if (tick && dual && !dir_q && at_top) begin
			dir_q <= 1'b1;
		end else if (tick && dual && dir_q && at_bottom) begin
			dir_q <= 1'b0;
		end
	end

	assign hw_update = (wave_mode == TCF_WAVE_NORMAL
		|| wave_mode == TCF_WAVE_FRQ) ? top_hit : bottom_hit;
	assign update_go = (hw_update || cmd_update)
		&& (!hold_q || core.capture_mode);

	always_ff @(posedge clk) begin
		if (!rst_n || hard_rst) begin
			top_q <= TCF_TOP_RST;
		end else if (wide_wr && hit_top) begin
			top_q <= wide_data;
		end else if (update_go && top_bv_q) begin
			top_q <= topbuf_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || hard_rst) begin
			topbuf_q <= TCF_TOP_RST;
		end else if (wide_wr && hit_topbuf) begin
			topbuf_q <= wide_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || hard_rst) begin
			top_bv_q <= 1'b0;
		end else begin
			top_bv_q <= (wide_wr && hit_topbuf)
				|| (g_set_wr && bus.wdata[TCF_TOP_BV_BIT])
				|| (top_bv_q && !update_go
				&& !(g_clr_wr && bus.wdata[TCF_TOP_BV_BIT]));
		end
	end

	// capture event actions turn every channel to capture behaviour
	for (genvar i = 0; i < TCF_CHANNELS; i++) begin : g_chan
		localparam logic [4:0] CC_W = 5'(TCF_OFF_CC[5:1] + 5'(i));
		localparam logic [4:0] BUF_W = 5'(TCF_OFF_CCBUF[5:1] + 5'(i));
		logic flag_clr;
		assign cc_hit[i] = wide_sel && widx == CC_W;
		assign buf_hit[i] = wide_sel && widx == BUF_W;
		assign flag_clr = (flags_wr && bus.wdata[TCF_CHAN_FLAG_LSB + i])
			|| (ack.chan[i] && !core.capture_mode)
			|| (bus.dma && (bus.rd || bus.wr) && (cc_hit[i] || buf_hit[i]))
			|| (core.capture_mode && bus.rd && cc_hit[i] && !bus.addr[0]);
		tcf_channel u_chan (
			.clk(clk),
			.rst_n(rst_n),
			.capture_mode(core.capture_mode),
			.hard_reset(hard_rst),
			.count_value(count_q),
			.count_moved(count_moved_q),
			.capture_event(core.capture_event[i]),
			.cc_wr(wide_wr && cc_hit[i]),
			.buf_wr(wide_wr && buf_hit[i]),
			.wr_data(wide_data),
			.update_go(update_go),
			.bv_set(g_set_wr && bus.wdata[TCF_CHAN_BV_LSB + i]),
			.bv_clr(g_clr_wr && bus.wdata[TCF_CHAN_BV_LSB + i]),
			.flag_clr(flag_clr),
			.cc_q(cc_val[i]),
			.buf_q(buf_val[i]),
			.bv_q(bv[i]),
			.flag_q(chan_flag[i]),
			.match(channel_match[i]),
			.overrun(overrun[i])
		);
		assign irq_channel_level[2 * i +: 2] =
			chan_flag[i] ? lvl_b_q[2 * i +: 2] : 2'h0;
	end

	assign fault_set = (core.fault_event && wave_mode != TCF_WAVE_NORMAL
		&& !core.capture_mode) || (|overrun) || core.index_error;

	always_ff @(posedge clk) begin
		if (!rst_n || hard_rst) begin
			fault_flag_q <= 1'b0;
		end else begin
			fault_flag_q <= fault_set || (fault_flag_q && !ack.fault
				&& !(flags_wr && bus.wdata[TCF_FAULT_FLAG_BIT]));
		end
	end

	always_comb begin
		case (wave_mode)
			TCF_WAVE_NORMAL, TCF_WAVE_FRQ, TCF_WAVE_DS_T: begin
				wrap_event = top_hit;
			end
			TCF_WAVE_SS, TCF_WAVE_DS_B: begin
				wrap_event = bottom_hit;
			end
			TCF_WAVE_DS_TB: begin
				wrap_event = top_hit || bottom_hit;
			end
			default: begin
				wrap_event = 1'b0;
			end
		endcase
	end

	assign wrap_clr = ack.wrap
		|| (flags_wr && bus.wdata[TCF_WRAP_FLAG_BIT])
		|| (bus.dma && wide_wr && (hit_cnt || hit_top || hit_topbuf));

	always_ff @(posedge clk) begin
		if (!rst_n || hard_rst) begin
			wrap_flag_q <= 1'b0;
		end else begin
			wrap_flag_q <= wrap_event || (wrap_flag_q && !wrap_clr);
		end
	end

	always_comb begin
		case (widx)
			TCF_OFF_CNT[5:1]: wide_value = count_q;
			TCF_OFF_TOP[5:1]: wide_value = top_q;
			TCF_OFF_TOPBUF[5:1]: wide_value = topbuf_q;
			TCF_OFF_CC[5:1]: wide_value = cc_val[0];
			5'(TCF_OFF_CC[5:1] + 5'h1): wide_value = cc_val[1];
			5'(TCF_OFF_CC[5:1] + 5'h2): wide_value = cc_val[2];
			5'(TCF_OFF_CC[5:1] + 5'h3): wide_value = cc_val[3];
			TCF_OFF_CCBUF[5:1]: wide_value = buf_val[0];
			5'(TCF_OFF_CCBUF[5:1] + 5'h1): wide_value = buf_val[1];
			5'(TCF_OFF_CCBUF[5:1] + 5'h2): wide_value = buf_val[2];
			5'(TCF_OFF_CCBUF[5:1] + 5'h3): wide_value = buf_val[3];
			default: wide_value = TCF_WIDE_RST;
		endcase
	end

	// command field always reads back as zero
	always_comb begin
		case (bus.addr)
			TCF_OFF_LVL_A: rd_d = {4'h0, lvl_a_q};
			TCF_OFF_LVL_B: rd_d = lvl_b_q;
			TCF_OFF_F_CLR, TCF_OFF_F_SET: rd_d = {6'h00, hold_q, dir_q};
			TCF_OFF_G_CLR, TCF_OFF_G_SET: rd_d = {3'h0, bv, top_bv_q};
			TCF_OFF_FLAGS: rd_d = {chan_flag, 2'h0, fault_flag_q, wrap_flag_q};
			TCF_OFF_TEMP: rd_d = latch_byte;
			default: begin
				if (!wide_sel) begin
					rd_d = TCF_BYTE_RST;
				end else if (bus.addr[0]) begin
					rd_d = latch_byte;
				end else begin
					rd_d = wide_value[7:0];
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_q <= TCF_BYTE_RST;
			update_q <= 1'b0;
		end else begin
			rdata_q <= bus.rd ? rd_d : TCF_BYTE_RST;
			update_q <= update_go;
		end
	end

	assign rdata = rdata_q;
	assign update_strobe = update_q;
	assign count_value = count_q;
	assign count_dir = dir_q;
	assign irq_fault_level = fault_flag_q ? lvl_a_q[TCF_FAULT_LVL_LSB +: 2] : 2'h0;
	assign irq_wrap_level = wrap_flag_q ? lvl_a_q[TCF_WRAP_LVL_LSB +: 2] : 2'h0;
	assign dma_req_channel = chan_flag;
	assign dma_req_wrap = wrap_flag_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_topbuf_write;
		wide_wr && hit_topbuf && !hard_rst;
	endsequence
	sequence s_free_update;
		update_go && !(wide_wr && hit_top) && !hard_rst;
	endsequence

	topbuf_load_a: assert property (s_topbuf_write ##1 s_free_update
		|=> top_q == $past(topbuf_q)) else $error("top limit not loaded");
	topbv_set_a: assert property (s_topbuf_write |=> top_bv_q)
		else $error("top buffer valid not set");
	hold_freeze_a: assert property (hold_q && !core.capture_mode
		&& !(wide_wr && hit_top) && !hard_rst |=> $stable(top_q))
		else $error("top limit moved while held");
	count_wins_a: assert property (wide_wr && hit_cnt
		|=> count_q == $past(wide_data)) else $error("count write lost");
	cmd_zero_a: assert property (bus.rd && bus.addr == TCF_OFF_F_SET
		|=> rdata[3:2] == 2'h0) else $error("command field read nonzero");
	hard_reset_a: assert property (hard_rst && !(wide_wr && hit_cnt)
		|=> count_q == TCF_WIDE_RST && top_q == TCF_TOP_RST)
		else $error("hard reset incomplete");
	dir_write_a: assert property (f_set_wr && bus.wdata[TCF_DIR_BIT]
		|=> count_dir) else $error("direction write ignored");
	wrap_w1c_a: assert property (flags_wr && bus.wdata[TCF_WRAP_FLAG_BIT]
		&& !wrap_event |=> !wrap_flag_q) else $error("wrap flag not cleared");
	wrap_dma_a: assert property (bus.dma && wide_wr && hit_cnt
		&& !wrap_event |=> !dma_req_wrap) else $error("wrap request kept");
	wrap_level_a: assert property (wrap_event && lvl_a_q[1:0] != 2'h0
		&& !(bus.wr && bus.addr == TCF_OFF_LVL_A) && !hard_rst
		|=> irq_wrap_level == $past(lvl_a_q[1:0]))
		else $error("wrap level wrong");
endmodule : tcf_timer_regs

// >>> verilog/tcf_pkg.sv
// Constants, types and register layout of the timer control and flag layer.
// Assumes an 8-bit peripheral bus with six address bits from the core.
package tcf_pkg;
	localparam int TCF_CHANNELS = 4;
	localparam logic [5:0] TCF_OFF_LVL_A = 6'h06;
	localparam logic [5:0] TCF_OFF_LVL_B = 6'h07;
	localparam logic [5:0] TCF_OFF_F_CLR = 6'h08;
	localparam logic [5:0] TCF_OFF_F_SET = 6'h09;
	localparam logic [5:0] TCF_OFF_G_CLR = 6'h0A;
	localparam logic [5:0] TCF_OFF_G_SET = 6'h0B;
	localparam logic [5:0] TCF_OFF_FLAGS = 6'h0C;
	localparam logic [5:0] TCF_OFF_TEMP = 6'h0F;
	localparam logic [5:0] TCF_OFF_CNT = 6'h20;
	localparam logic [5:0] TCF_OFF_TOP = 6'h26;
	localparam logic [5:0] TCF_OFF_CC = 6'h28;
	localparam logic [5:0] TCF_OFF_TOPBUF = 6'h36;
	localparam logic [5:0] TCF_OFF_CCBUF = 6'h38;
	localparam int TCF_FAULT_LVL_LSB = 2;
	localparam int TCF_WRAP_LVL_LSB = 0;
	localparam int TCF_CMD_LSB = 2;
	localparam int TCF_HOLD_BIT = 1;
	localparam int TCF_DIR_BIT = 0;
	localparam int TCF_TOP_BV_BIT = 0;
	localparam int TCF_CHAN_BV_LSB = 1;
	localparam int TCF_CHAN_FLAG_LSB = 4;
	localparam int TCF_FAULT_FLAG_BIT = 1;
	localparam int TCF_WRAP_FLAG_BIT = 0;
	localparam logic [15:0] TCF_TOP_RST = 16'hFFFF;
	localparam logic [15:0] TCF_WIDE_RST = 16'h0000;
	localparam logic [7:0] TCF_BYTE_RST = 8'h00;
	typedef enum logic [1:0] {
		TCF_CMD_NONE = 2'h0,
		TCF_CMD_UPDATE = 2'h1,
		TCF_CMD_RESTART = 2'h2,
		TCF_CMD_RESET = 2'h3
	} tcf_cmd_type;
	typedef enum logic [2:0] {
		TCF_WAVE_NORMAL = 3'h0,
		TCF_WAVE_FRQ = 3'h1,
		TCF_WAVE_SS = 3'h3,
		TCF_WAVE_DS_T = 3'h5,
		TCF_WAVE_DS_TB = 3'h6,
		TCF_WAVE_DS_B = 3'h7
	} tcf_wave_type;
	typedef struct packed {
		logic wr;
		logic rd;
		logic dma;
		logic [5:0] addr;
		logic [7:0] wdata;
	} tcf_bus_type;
	typedef struct packed {
		logic count_tick;
		logic clock_off;
		logic capture_mode;
		logic hw_restart;
		logic dir_load;
		logic dir_value;
		logic fault_event;
		logic index_error;
		logic [3:0] capture_event;
	} tcf_core_type;
	typedef struct packed {
		logic wrap;
		logic fault;
		logic [3:0] chan;
	} tcf_ack_type;
endpackage : tcf_pkg

// >>> verilog/tcf_wide_access.sv
// Byte latches that pair 8-bit bus cycles into 16-bit register accesses.
// Assumes low byte is accessed first on write and on read.
`timescale 1ns/1ns
module tcf_wide_access import tcf_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire tcf_bus_type bus,
	input wire logic wide_sel,
	input wire logic [15:0] wide_value,
	output logic wide_wr,
	output logic [15:0] wide_data,
	output logic [7:0] latch_byte
);
	logic [7:0] cpu_temp_q;
	logic [7:0] dma_temp_q;
	logic low_wr;
	logic low_rd;

	assign low_wr = bus.wr && wide_sel && !bus.addr[0];
	assign low_rd = bus.rd && wide_sel && !bus.addr[0];

	// one latch shared by every wide register for the cpu
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cpu_temp_q <= TCF_BYTE_RST;
		end else if (!bus.dma) begin
			if (bus.wr && bus.addr == TCF_OFF_TEMP) begin
				cpu_temp_q <= bus.wdata;
			end else if (low_wr) begin
				cpu_temp_q <= bus.wdata;
			end else if (low_rd) begin
				cpu_temp_q <= wide_value[15:8];
			end
		end
	end

	// separate store so dma traffic never corrupts a cpu access
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dma_temp_q <= TCF_BYTE_RST;
		end else if (bus.dma) begin
			if (low_wr) begin
				dma_temp_q <= bus.wdata;
			end else if (low_rd) begin
				dma_temp_q <= wide_value[15:8];
			end
		end
	end

	assign latch_byte = bus.dma ? dma_temp_q : cpu_temp_q;
	assign wide_wr = bus.wr && wide_sel && bus.addr[0];
	assign wide_data = {bus.wdata, latch_byte};
endmodule : tcf_wide_access

// >>> verilog/tcf_channel.sv
// One compare/capture channel: active value, buffer, valid bit and flag.
// Assumes strobes arrive as single-cycle pulses from the register layer.
`timescale 1ns/1ns
module tcf_channel import tcf_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic capture_mode,
	input wire logic hard_reset,
	input wire logic [15:0] count_value,
	input wire logic count_moved,
	input wire logic capture_event,
	input wire logic cc_wr,
	input wire logic buf_wr,
	input wire logic [15:0] wr_data,
	input wire logic update_go,
	input wire logic bv_set,
	input wire logic bv_clr,
	input wire logic flag_clr,
	output logic [15:0] cc_q,
	output logic [15:0] buf_q,
	output logic bv_q,
	output logic flag_q,
	output logic match,
	output logic overrun
);
	logic cap_take;

	assign cap_take = capture_mode && capture_event && !bv_q;
	assign overrun = capture_mode && capture_event && bv_q;
	assign match = !capture_mode && count_moved && count_value == cc_q;

	always_ff @(posedge clk) begin
		if (!rst_n || hard_reset) begin
			cc_q <= TCF_WIDE_RST;
		end else if (cc_wr) begin
			cc_q <= wr_data;
		end else if (cap_take) begin
			cc_q <= count_value;
		end else if (!capture_mode && update_go && bv_q) begin
			cc_q <= buf_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || hard_reset) begin
			buf_q <= TCF_WIDE_RST;
		end else if (buf_wr) begin
			buf_q <= wr_data;
		end else if (cap_take) begin
			buf_q <= count_value;
		end
	end

	// set wins over clear
	always_ff @(posedge clk) begin
		if (!rst_n || hard_reset) begin
			bv_q <= 1'b0;
		end else begin
			bv_q <= (buf_wr && !capture_mode) || cap_take || bv_set
				|| (bv_q && !(bv_clr || (!capture_mode && update_go)
				|| (capture_mode && flag_clr)));
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || hard_reset) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= (capture_mode ? cap_take : match)
				|| (flag_q && !flag_clr);
		end
	end
endmodule : tcf_channel

// >>> sim/timer_counter_ctrl_flags_tb_top.sv
// Self-checking bench for the timer control and flag register layer.
// Assumes the design package and the register top module are compiled first.
`timescale 1ns/1ns
module timer_counter_ctrl_flags_tb_top import tcf_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	tcf_bus_type bus = '0;
	tcf_wave_type wave_mode = TCF_WAVE_NORMAL;
	tcf_core_type core = '0;
	tcf_ack_type ack = '0;
	logic [7:0] rdata;
	logic [15:0] count_value;
	logic count_dir;
	logic update_strobe;
	logic [3:0] channel_match;
	logic [1:0] irq_fault_level;
	logic [1:0] irq_wrap_level;
	logic [7:0] irq_channel_level;
	logic [3:0] dma_req_channel;
	logic dma_req_wrap;
	int n_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	integer seed = 32'hBD451A03;
	logic [7:0] d;
	logic [15:0] v;
	logic [15:0] r;

	tcf_timer_regs tcf_timer_regs_inst (.clk(clk), .rst_n(rst_n), .bus(bus),
		.wave_mode(wave_mode), .core(core), .ack(ack), .rdata(rdata),
		.count_value(count_value), .count_dir(count_dir),
		.update_strobe(update_strobe), .channel_match(channel_match),
		.irq_fault_level(irq_fault_level), .irq_wrap_level(irq_wrap_level),
		.irq_channel_level(irq_channel_level),
		.dma_req_channel(dma_req_channel), .dma_req_wrap(dma_req_wrap));

	always #2 clk = ~clk;

	task automatic end_of_test;
		$display("checks %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_of_test

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			end_of_test();
		end
	end

	task automatic chk(input string nm, input logic [15:0] got,
		input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask : chk

	task automatic bw(input logic [5:0] a, input logic [7:0] wd,
		input logic dm = 1'b0);
		@(posedge clk);
		#1 bus = '{wr: 1'b1, rd: 1'b0, dma: dm, addr: a, wdata: wd};
		@(posedge clk);
		#1 bus = '0;
	endtask : bw

	task automatic br(input logic [5:0] a, output logic [7:0] rd_v,
		input logic dm = 1'b0);
		@(posedge clk);
		#1 bus = '{wr: 1'b0, rd: 1'b1, dma: dm, addr: a, wdata: 8'h00};
		@(posedge clk);
		#1 bus = '0;
		rd_v = rdata;
	endtask : br

	task automatic w16(input logic [5:0] a, input logic [15:0] wv);
		bw(a, wv[7:0]);
		bw(a + 6'h01, wv[15:8]);
	endtask : w16

	task automatic r16(input logic [5:0] a, output logic [15:0] rv);
		br(a, rv[7:0]);
		br(a + 6'h01, rv[15:8]);
	endtask : r16

	// ticks every cycle until the wrap flag rises, bounded
	task automatic raise_wrap;
		w16(TCF_OFF_CNT, 16'h0000);
		core.count_tick = 1'b1;
		for (int i = 0; i < 16 && dma_req_wrap !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		core.count_tick = 1'b0;
		chk("wrap_flag", dma_req_wrap, 16'h0001);
	endtask : raise_wrap

	// one-cycle capture event on channel i
	task automatic cap(input int i);
		core.capture_event[i] = 1'b1;
		@(posedge clk);
		#1 core.capture_event[i] = 1'b0;
	endtask : cap

	initial begin
		repeat (3) @(posedge clk);
		#1 rst_n = 1'b1;
		r16(TCF_OFF_TOP, r);
		chk("top_rst", r, TCF_TOP_RST);
		br(6'h05, d);
		chk("unmapped", d, 16'h0000);
		br(TCF_OFF_LVL_B, d);
		chk("chan_lvl_rst", d, 16'h0000);
		v = 16'($random(seed));
		bw(TCF_OFF_LVL_B, v[7:0]);
		br(TCF_OFF_LVL_B, d);
		chk("chan_lvl", d, {8'h00, v[7:0]});
		chk("chan_irq_idle", irq_channel_level, 16'h0000);
		bw(TCF_OFF_G_SET, 8'h1F);
		br(TCF_OFF_G_CLR, d);
		chk("bv_clr_loc", d, 16'h001F);
		bw(TCF_OFF_G_CLR, 8'h05);
		br(TCF_OFF_G_SET, d);
		chk("bv_set_loc", d, 16'h001A);
		bw(TCF_OFF_F_SET, 8'h04);
		br(TCF_OFF_G_SET, d);
		chk("bv_update", d, 16'h0000);
		bw(TCF_OFF_F_SET, 8'h01);
		chk("dir_down", count_dir, 16'h0001);
		br(TCF_OFF_F_CLR, d);
		chk("ctrl_f", d, 16'h0001);
		bw(TCF_OFF_F_CLR, 8'h01);
		chk("dir_up", count_dir, 16'h0000);
		bw(TCF_OFF_TOP, 8'h03);
		br(TCF_OFF_TEMP, d);
		chk("cpu_latch", d, 16'h0003);
		bw(TCF_OFF_TOP + 6'h01, 8'h00);
		w16(TCF_OFF_CC, 16'h0002);
		v = 16'($unsigned($random(seed)) % 3);
		core.count_tick = 1'b1;
		w16(TCF_OFF_CNT, v);
		chk("cnt_write_wins", count_value, v);
		core.count_tick = 1'b0;
		bw(TCF_OFF_LVL_A, 8'h07);
		raise_wrap();
		chk("wrap_lvl", irq_wrap_level, 16'h0003);
		chk("fault_lvl", irq_fault_level, 16'h0000);
		chk("ch_flag", dma_req_channel[0], 16'h0001);
		bw(TCF_OFF_LVL_B, 8'h02);
		chk("ch_lvl_irq", irq_channel_level, 16'h0002);
		br(TCF_OFF_FLAGS, d);
		chk("flags", {d[4], d[0]}, 16'h0003);
		bw(TCF_OFF_FLAGS, 8'h01);
		chk("wrap_w1c", dma_req_wrap, 16'h0000);
		ack.chan = 4'h1;
		@(posedge clk);
		#1 ack.chan = 4'h0;
		@(posedge clk);
		#1 chk("ch_ack", dma_req_channel[0], 16'h0000);
		raise_wrap();
		ack.wrap = 1'b1;
		@(posedge clk);
		#1 ack.wrap = 1'b0;
		@(posedge clk);
		#1 chk("wrap_ack", dma_req_wrap, 16'h0000);
		br(TCF_OFF_CC, d, 1'b1);
		chk("ch_dma", dma_req_channel[0], 16'h0000);
		w16(TCF_OFF_CNT, 16'h0002);
		chk("ch_match", channel_match, 16'h0001);
		raise_wrap();
		bw(TCF_OFF_CNT + 6'h01, 8'h00, 1'b1);
		chk("wrap_dma", dma_req_wrap, 16'h0000);
		bw(TCF_OFF_F_SET, 8'h02);
		v = 16'($random(seed));
		w16(TCF_OFF_TOPBUF, v);
		bw(TCF_OFF_F_SET, 8'h04);
		chk("held_strobe", update_strobe, 16'h0000);
		r16(TCF_OFF_TOP, r);
		chk("hold_top", r, 16'h0003);
		bw(TCF_OFF_F_CLR, 8'h02);
		bw(TCF_OFF_F_SET, 8'h04);
		chk("upd_strobe", update_strobe, 16'h0001);
		r16(TCF_OFF_TOP, r);
		chk("update_top", r, v);
		core.capture_mode = 1'b1;
		cap(1);
		chk("cap_flag", dma_req_channel[1], 16'h0001);
		cap(1);
		chk("cap_overrun", irq_fault_level, 16'h0001);
		bw(TCF_OFF_FLAGS, 8'h02);
		chk("fault_w1c", irq_fault_level, 16'h0000);
		br(6'h2A, d);
		chk("cap_read", dma_req_channel[1], 16'h0000);
		br(TCF_OFF_G_SET, d);
		chk("cap_bv", d[2], 16'h0000);
		cap(2);
		cap(2);
		ack.fault = 1'b1;
		ack.chan = 4'h4;
		@(posedge clk);
		#1 ack.fault = 1'b0;
		ack.chan = 4'h0;
		chk("fault_ack", irq_fault_level, 16'h0000);
		chk("cap_ack_kept", dma_req_channel[2], 16'h0001);
		core.capture_mode = 1'b0;
		bw(TCF_OFF_F_SET, 8'h0C);
		br(TCF_OFF_LVL_A, d);
		chk("reset_ignored", d, 16'h0007);
		core.clock_off = 1'b1;
		bw(TCF_OFF_F_SET, 8'h0C);
		br(TCF_OFF_LVL_A, d);
		chk("hard_reset", d, 16'h0000);
		r16(TCF_OFF_TOP, r);
		chk("hard_reset_top", r, TCF_TOP_RST);
		wave_mode = TCF_WAVE_DS_B;
		w16(TCF_OFF_TOP, 16'h0002);
		raise_wrap();
		chk("ds_count", count_value, 16'h0001);
		core.fault_event = 1'b1;
		@(posedge clk);
		#1 core.fault_event = 1'b0;
		br(TCF_OFF_FLAGS, d);
		chk("ext_fault", d[1], 16'h0001);
		end_of_test();
	end
endmodule : timer_counter_ctrl_flags_tb_top
